//--- hw/irq_vec_regs.svh
// Purpose: Sizes, priority numbers and vector addresses of the vectoring block
// Assumes: Included by its bare name from the package and the design files
// Notes:   Priority number doubles as the request index; zero is served first after the software interrupt
`ifndef IRQ_VEC_REGS_SVH
`define IRQ_VEC_REGS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define NUM_SRC 31
`define IDX_W 5
`define VEC_W 16
// Index used for the software interrupt, above every maskable one
`define IDX_SWI 5'h1f

// ****************************************************************
// Default priorities (request index)
// ****************************************************************
`define PRI_WDT 5'h00
`define PRI_LVI 5'h01
`define PRI_PIN_A 5'h02
`define PRI_PIN_B 5'h03
`define PRI_PIN_C 5'h04
`define PRI_S3_TX 5'h05
`define PRI_S3_RX 5'h06
`define PRI_S3_ERR 5'h07
`define PRI_DMA0 5'h08
`define PRI_DMA1 5'h09
`define PRI_CS0 5'h0a
`define PRI_S1_TX 5'h0b
`define PRI_S1_RX 5'h0c
`define PRI_S1_ERR 5'h0d
`define PRI_U0_CH0 5'h0e
`define PRI_U0_CH1 5'h0f
`define PRI_U0_CH2 5'h10
`define PRI_U0_CH3 5'h11
`define PRI_RTC_CYC 5'h12
`define PRI_RTC_INT 5'h13
`define PRI_S2_TX 5'h14
`define PRI_U1_CH3 5'h15
`define PRI_U0_CH4 5'h16
`define PRI_U0_CH5 5'h17
`define PRI_U0_CH6 5'h18
`define PRI_U0_CH7 5'h19
`define PRI_PIN_D 5'h1a
`define PRI_U1_CH0 5'h1b
`define PRI_U1_CH1 5'h1c
`define PRI_U1_CH2 5'h1d
`define PRI_DIV 5'h1e

// ****************************************************************
// Vector table addresses
// ****************************************************************
`define VEC_WDT 16'h0004
`define VEC_LVI 16'h0006
`define VEC_PIN_A 16'h0008
`define VEC_PIN_B 16'h0010
`define VEC_PIN_C 16'h0012
`define VEC_S3_TX 16'h0014
`define VEC_S3_RX 16'h0016
`define VEC_S3_ERR 16'h0018
`define VEC_DMA0 16'h001a
`define VEC_DMA1 16'h001c
`define VEC_CS0 16'h001e
`define VEC_S1_TX 16'h0024
`define VEC_S1_RX 16'h0026
`define VEC_S1_ERR 16'h0028
`define VEC_U0_CH0 16'h002c
`define VEC_U0_CH1 16'h002e
`define VEC_U0_CH2 16'h0030
`define VEC_U0_CH3 16'h0032
`define VEC_RTC_CYC 16'h0036
`define VEC_RTC_INT 16'h0038
`define VEC_S2_TX 16'h003c
`define VEC_U1_CH3 16'h0040
`define VEC_U0_CH4 16'h0042
`define VEC_U0_CH5 16'h0044
`define VEC_U0_CH6 16'h0046
`define VEC_U0_CH7 16'h0048
`define VEC_PIN_D 16'h0052
`define VEC_U1_CH0 16'h0056
`define VEC_U1_CH1 16'h0058
`define VEC_U1_CH2 16'h005a
`define VEC_DIV 16'h005e
// Software interrupt vector, plain default
`define VEC_SWI 16'h007e

`endif

//--- hw/irq_vec_pkg.sv
// Purpose: Types shared by the vectoring block
// Assumes: Constants come from the regs header
// Notes:   Holds types only
`include "irq_vec_regs.svh"
package irq_vec_pkg;
  // Request index, also the default priority number
  typedef logic [`IDX_W-1:0] src_idx_t;
  // Vector table address
  typedef logic [`VEC_W-1:0] vec_addr_t;
  // Grant sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOOKUP = 2'b01,
    ST_OFFER = 2'b10
  } grant_state_t;
endpackage

//--- hw/vector_rom.sv
// Purpose: Vector table lookup with a registered read port
// Assumes: Address is the request index, one cycle read latency
// Notes:   Unused index answers with the software vector
`timescale 1ns/1ps
`include "irq_vec_regs.svh"
module vector_rom import irq_vec_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire src_idx_t addr_i,
  output vec_addr_t data_o
);
  // Registered read, cleared by reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      data_o <= 16'h0000;
    end else begin
      case (addr_i)
        `PRI_WDT: data_o <= `VEC_WDT;
        `PRI_LVI: data_o <= `VEC_LVI;
        `PRI_PIN_A: data_o <= `VEC_PIN_A;
        `PRI_PIN_B: data_o <= `VEC_PIN_B;
        `PRI_PIN_C: data_o <= `VEC_PIN_C;
        `PRI_PIN_D: data_o <= `VEC_PIN_D;
        `PRI_S3_TX: data_o <= `VEC_S3_TX;
        `PRI_S3_RX: data_o <= `VEC_S3_RX;
        `PRI_S3_ERR: data_o <= `VEC_S3_ERR;
        `PRI_DMA0: data_o <= `VEC_DMA0;
        `PRI_DMA1: data_o <= `VEC_DMA1;
        `PRI_CS0: data_o <= `VEC_CS0;
        `PRI_S1_TX: data_o <= `VEC_S1_TX;
        `PRI_S1_RX: data_o <= `VEC_S1_RX;
        `PRI_S1_ERR: data_o <= `VEC_S1_ERR;
        `PRI_U0_CH0: data_o <= `VEC_U0_CH0;
        `PRI_U0_CH1: data_o <= `VEC_U0_CH1;
        `PRI_U0_CH2: data_o <= `VEC_U0_CH2;
        `PRI_U0_CH3: data_o <= `VEC_U0_CH3;
        `PRI_U0_CH4: data_o <= `VEC_U0_CH4;
        `PRI_U0_CH5: data_o <= `VEC_U0_CH5;
        `PRI_U0_CH6: data_o <= `VEC_U0_CH6;
        `PRI_U0_CH7: data_o <= `VEC_U0_CH7;
        `PRI_RTC_CYC: data_o <= `VEC_RTC_CYC;
        `PRI_RTC_INT: data_o <= `VEC_RTC_INT;
        `PRI_S2_TX: data_o <= `VEC_S2_TX;
        `PRI_U1_CH3: data_o <= `VEC_U1_CH3;
        `PRI_U1_CH0: data_o <= `VEC_U1_CH0;
        `PRI_U1_CH1: data_o <= `VEC_U1_CH1;
        `PRI_U1_CH2: data_o <= `VEC_U1_CH2;
        `PRI_DIV: data_o <= `VEC_DIV;
        default: data_o <= `VEC_SWI;
      endcase
    end
  end
endmodule // vector_rom

//--- hw/irq_vectoring.sv
// Purpose: Collects interrupt requests, arbitrates by fixed priority, offers a vector
// Assumes: Sources pulse for a cycle; all inputs synchronous to CORE_CLK_I
// Notes:   One grant at a time; acknowledge clears the granted pending flag
`timescale 1ns/1ps
`include "irq_vec_regs.svh"
module irq_vectoring import irq_vec_pkg::*; (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic WATCHDOG_INTERVAL_REQ_I,
  input wire logic LOW_VOLTAGE_REQ_I,
  input wire logic PIN_EDGE_REQ_A_I,
  input wire logic PIN_EDGE_REQ_B_I,
  input wire logic PIN_EDGE_REQ_C_I,
  input wire logic PIN_EDGE_REQ_D_I,
  input wire logic SERIAL3_TX_REQ_I,
  input wire logic SERIAL3_RX_REQ_I,
  input wire logic SERIAL3_ERR_REQ_I,
  input wire logic DMA_CH0_DONE_REQ_I,
  input wire logic DMA_CH1_DONE_REQ_I,
  input wire logic CLOCKED_SERIAL0_REQ_I,
  input wire logic SERIAL1_TX_REQ_I,
  input wire logic CLOCKED_SERIAL1_REQ_I,
  input wire logic TWO_WIRE1_REQ_I,
  input wire logic SERIAL1_RX_REQ_I,
  input wire logic SERIAL1_ERR_REQ_I,
  input wire logic [7:0] TIMER_U0_REQ_I,
  input wire logic [3:0] TIMER_U1_REQ_I,
  input wire logic RTC_CYCLE_ALARM_REQ_I,
  input wire logic RTC_INTERVAL_REQ_I,
  input wire logic SERIAL2_TX_REQ_I,
  input wire logic DIVIDE_DONE_REQ_I,
  input wire logic BREAK_INSTRUCTION_I,
  input wire logic WATCHDOG_INTERVAL_ENABLE_I,
  input wire logic LOW_VOLTAGE_RESET_SELECT_I,
  input wire logic [`NUM_SRC-1:0] MASK_I,
  input wire logic ACK_I,
  output logic INT_REQ_O,
  output vec_addr_t VECTOR_O,
  output src_idx_t INT_SRC_O,
  output logic [`NUM_SRC-1:0] PENDING_O
);

  // ****************************************************************
  // Request collection
  // ****************************************************************

  // Raw request per index, ordered by default priority
  logic [`NUM_SRC-1:0] raw_req;
  // Sticky pending flags
  logic [`NUM_SRC-1:0] pend;
  // One-hot clear from the acknowledge
  logic [`NUM_SRC-1:0] clr_vec;
  // Pending and not masked
  logic [`NUM_SRC-1:0] eligible;
  // Software interrupt waiting
  logic swi_pend;
  // Sequencer state
  grant_state_t state;
  // Index under grant
  src_idx_t grant_idx;
  // Winner of the current arbitration
  src_idx_t winner;
  // Any request ready to grant
  logic pick;
  // Vector read back from the table
  vec_addr_t rom_data;
  // Acknowledge taken this cycle
  logic ack_take;

  // Map the source ports onto priority indices
  always_comb begin
    raw_req = '0;
    raw_req[`PRI_WDT] = WATCHDOG_INTERVAL_REQ_I & WATCHDOG_INTERVAL_ENABLE_I;
    raw_req[`PRI_LVI] = LOW_VOLTAGE_REQ_I & ~LOW_VOLTAGE_RESET_SELECT_I;
    raw_req[`PRI_PIN_A] = PIN_EDGE_REQ_A_I;
    raw_req[`PRI_PIN_B] = PIN_EDGE_REQ_B_I;
    raw_req[`PRI_PIN_C] = PIN_EDGE_REQ_C_I;
    raw_req[`PRI_PIN_D] = PIN_EDGE_REQ_D_I;
    raw_req[`PRI_S3_TX] = SERIAL3_TX_REQ_I;
    raw_req[`PRI_S3_RX] = SERIAL3_RX_REQ_I;
    raw_req[`PRI_S3_ERR] = SERIAL3_ERR_REQ_I;
    raw_req[`PRI_DMA0] = DMA_CH0_DONE_REQ_I;
    raw_req[`PRI_DMA1] = DMA_CH1_DONE_REQ_I;
    raw_req[`PRI_CS0] = CLOCKED_SERIAL0_REQ_I;
    raw_req[`PRI_S1_TX] = SERIAL1_TX_REQ_I | CLOCKED_SERIAL1_REQ_I | TWO_WIRE1_REQ_I;
    raw_req[`PRI_S1_RX] = SERIAL1_RX_REQ_I;
    raw_req[`PRI_S1_ERR] = SERIAL1_ERR_REQ_I;
    raw_req[`PRI_U0_CH0] = TIMER_U0_REQ_I[0];
    raw_req[`PRI_U0_CH1] = TIMER_U0_REQ_I[1];
    raw_req[`PRI_U0_CH2] = TIMER_U0_REQ_I[2];
    raw_req[`PRI_U0_CH3] = TIMER_U0_REQ_I[3];
    raw_req[`PRI_U0_CH4] = TIMER_U0_REQ_I[4];
    raw_req[`PRI_U0_CH5] = TIMER_U0_REQ_I[5];
    raw_req[`PRI_U0_CH6] = TIMER_U0_REQ_I[6];
    raw_req[`PRI_U0_CH7] = TIMER_U0_REQ_I[7];
    raw_req[`PRI_RTC_CYC] = RTC_CYCLE_ALARM_REQ_I;
    raw_req[`PRI_RTC_INT] = RTC_INTERVAL_REQ_I;
    raw_req[`PRI_S2_TX] = SERIAL2_TX_REQ_I;
    raw_req[`PRI_U1_CH0] = TIMER_U1_REQ_I[0];
    raw_req[`PRI_U1_CH1] = TIMER_U1_REQ_I[1];
    raw_req[`PRI_U1_CH2] = TIMER_U1_REQ_I[2];
    raw_req[`PRI_U1_CH3] = TIMER_U1_REQ_I[3];
    raw_req[`PRI_DIV] = DIVIDE_DONE_REQ_I;
  end

  // Acknowledge counts only while a grant is offered
  assign ack_take = (state == ST_OFFER) & ACK_I;

  // ****************************************************************
  // Pending flags
  // ****************************************************************

  // One flag per index; set beats clear so a fresh event is never dropped
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_SRC; gi++) begin : g_pend
      assign clr_vec[gi] = ack_take & (grant_idx == src_idx_t'(gi));
      always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
          pend[gi] <= 1'b0;
        end else begin
          pend[gi] <= raw_req[gi] | (pend[gi] & ~clr_vec[gi]);
        end
      end
    end
  endgenerate

  // Software interrupt flag, outside every mask
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      swi_pend <= 1'b0;
    end else begin
      // Break sets, its own acknowledge clears
      swi_pend <= BREAK_INSTRUCTION_I |
                  (swi_pend & ~(ack_take & (grant_idx == `IDX_SWI)));
    end
  end

  // Flags seen by the core, copied for a clean flop output
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      PENDING_O <= '0;
    end else begin
      PENDING_O <= pend;
    end
  end

  // ****************************************************************
  // Arbitration
  // ****************************************************************

  // Mask removes a request from arbitration
  assign eligible = pend & ~MASK_I;

  // Fixed priority search; lowest index wins, software interrupt first
  always_comb begin
    winner = `IDX_SWI;
    pick = swi_pend;
    if (!swi_pend) begin
      // Scan downward so index zero wins
      for (int i = `NUM_SRC - 1; i >= 0; i--) begin
        if (eligible[i]) begin
          winner = src_idx_t'(i);
          pick = 1'b1;
        end
      end
    end
  end

  // Vector table, read one cycle after the winner is chosen
  vector_rom u_rom (
    .clk_i(CORE_CLK_I),
    .resetn_i(RESETN_I),
    .addr_i(winner),
    .data_o(rom_data)
  );

  // ****************************************************************
  // Grant sequencer
  // ****************************************************************

  // Idle picks, lookup waits for the table, offer holds until acknowledge
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      state <= ST_IDLE;
      grant_idx <= '0;
    end else begin
      case (state)
        // Latch the winner; masking later does not withdraw it
        ST_IDLE: begin
          if (pick) begin
            grant_idx <= winner;
            state <= ST_LOOKUP;
          end
        end
        // Table output is now valid for the latched index
        ST_LOOKUP: begin
          state <= ST_OFFER;
        end
        // Wait for the core to take the vector
        ST_OFFER: begin
          if (ACK_I) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Request, vector and source number toward the core
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      INT_REQ_O <= 1'b0;
      VECTOR_O <= '0;
      INT_SRC_O <= '0;
    end else if (state == ST_LOOKUP) begin
      INT_REQ_O <= 1'b1;
      VECTOR_O <= rom_data;
      INT_SRC_O <= grant_idx;
    end else if (ack_take) begin
      // Drop the request on the acknowledge edge
      INT_REQ_O <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  // Mask and eligible bits captured at the pick, read at the offer
  logic [31:0] mask_at_pick;
  logic [31:0] elig_at_pick;
  // Snapshot on the pick edge, so the checks see what arbitration saw
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      mask_at_pick <= '0;
      elig_at_pick <= '0;
    end else if ((state == ST_IDLE) && pick) begin
      mask_at_pick <= {1'b0, MASK_I};
      elig_at_pick <= {1'b0, eligible};
    end
  end

  // Flags that must survive to the next cycle
  logic [`NUM_SRC-1:0] keep_vec;
  assign keep_vec = pend & ~clr_vec;

  // Start of an offer
  sequence s_offer_start;
    $rose(INT_REQ_O);
  endsequence

  // Offer still waiting on the core
  sequence s_offer_wait;
    INT_REQ_O && !ACK_I;
  endsequence

  // Software request seen while idle
  sequence s_swi_idle;
    swi_pend && (state == ST_IDLE);
  endsequence

  a_mask_blocks: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    s_offer_start and (INT_SRC_O != `IDX_SWI) |->
      ((mask_at_pick >> INT_SRC_O) & 32'h1) == 32'h0)
    else $error("masked request was offered");

  a_swi_vector: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    s_swi_idle |-> ##2 (INT_REQ_O && INT_SRC_O == `IDX_SWI && VECTOR_O == `VEC_SWI))
    else $error("break did not vector within two cycles");

  a_prio_order: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    s_offer_start and (INT_SRC_O != `IDX_SWI) |->
      (elig_at_pick & ((32'h1 << INT_SRC_O) - 32'h1)) == 32'h0)
    else $error("higher priority request was skipped");

  a_wdt_gate: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    $rose(pend[`PRI_WDT]) |-> $past(WATCHDOG_INTERVAL_ENABLE_I))
    else $error("watchdog interval pended while disabled");

  a_wdt_vector: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    s_offer_start and (INT_SRC_O == `PRI_WDT) |-> VECTOR_O == `VEC_WDT)
    else $error("wrong watchdog vector");

  a_lvi_gate: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    $rose(pend[`PRI_LVI]) |-> !$past(LOW_VOLTAGE_RESET_SELECT_I))
    else $error("low voltage pended in reset mode");

  a_pin_vector: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    s_offer_start and (INT_SRC_O == `PRI_PIN_D) |-> VECTOR_O == `VEC_PIN_D)
    else $error("wrong pin edge vector");

  a_div_vector: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    s_offer_start and (INT_SRC_O == `PRI_DIV) |-> VECTOR_O == `VEC_DIV)
    else $error("wrong divide done vector");

  a_pend_kept: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    1'b1 |=> (pend & $past(keep_vec)) == $past(keep_vec))
    else $error("pending request lost");

  a_offer_holds: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    s_offer_wait |=> INT_REQ_O && $stable(VECTOR_O) && $stable(INT_SRC_O))
    else $error("offer changed before acknowledge");

  a_ack_drops: assert property (
    @(posedge CORE_CLK_I) disable iff (!RESETN_I)
    INT_REQ_O && ACK_I |=> !INT_REQ_O ##1 !INT_REQ_O)
    else $error("request not dropped after acknowledge");

endmodule // irq_vectoring

//--- bench/core_fetch_model.sv
// Purpose: Processor core stand-in that takes offered vectors
// Assumes: Offer and acknowledge are sampled at the rising clock edge
// Notes:   Ack delay set by the bench makes the core prompt or slow
`timescale 1ns/1ps
module core_fetch_model import irq_vec_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic int_req_i,
  input wire vec_addr_t vector_i,
  input wire src_idx_t int_src_i,
  input wire logic stray_ack_i,
  input wire logic [31:0] delay_i,
  output logic ack_o,
  output vec_addr_t last_vec_o,
  output src_idx_t last_src_o,
  output int taken_o
);
  logic ack_q; // Held from raise until the taking edge
  int wait_cnt; // Cycles the current offer has waited
  // Stray ack lets the bench poke an idle block
  assign ack_o = ack_q | stray_ack_i;

  // ****************************************************************
  // Acknowledge and fetch
  // ****************************************************************
  // Ack is raised after a clock edge and held until the edge that takes it,
  // so the block never sees a half-cycle pulse
  // acknowledge, then fetch
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
      wait_cnt <= 0;
      last_vec_o <= '0;
      last_src_o <= '0;
      taken_o <= 0;
    end else if (ack_q && int_req_i) begin
      // Taking edge: fetch what is offered
      ack_q <= 1'b0;
      wait_cnt <= 0;
      last_vec_o <= vector_i;
      last_src_o <= int_src_i;
      taken_o <= taken_o + 1;
    end else if (int_req_i && !ack_q) begin
      // Offer waiting: stall for the chosen delay
      if (wait_cnt >= delay_i) begin
        ack_q <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule // core_fetch_model

//--- bench/tb.sv
// Purpose: Self-checking bench for the interrupt vectoring block
// Assumes: Inputs change at the falling edge, core model acks on rising
// Notes:   Source bit i of src drives the request with priority index i
`timescale 1ns/1ps
`include "irq_vec_regs.svh"
module tb import irq_vec_pkg::*;;
  logic clk = 0, rstn = 0, break_instruction = 0, wdt_en = 1, lv_sel = 0, cs1 = 0, tw1 = 0, stray = 0;
  logic [30:0] src = '0; // Request pulses by index
  logic [30:0] mask = '0; // Mask levels by index
  int delay = 0, err_count = 0, compares = 0, seen = 0;
  logic int_req, ack;
  vec_addr_t vec, lvec;
  src_idx_t isrc, lsrc;
  logic [30:0] pend;
  int taken;
  vec_addr_t exp_vec [0:31]; // Expected vector by index, 31 is software
  always #25 clk = ~clk;

  irq_vectoring i_dut (.CORE_CLK_I(clk), .RESETN_I(rstn),
    .WATCHDOG_INTERVAL_REQ_I(src[0]), .LOW_VOLTAGE_REQ_I(src[1]),
    .PIN_EDGE_REQ_A_I(src[2]), .PIN_EDGE_REQ_B_I(src[3]), .PIN_EDGE_REQ_C_I(src[4]),
    .PIN_EDGE_REQ_D_I(src[26]), .SERIAL3_TX_REQ_I(src[5]), .SERIAL3_RX_REQ_I(src[6]),
    .SERIAL3_ERR_REQ_I(src[7]), .DMA_CH0_DONE_REQ_I(src[8]), .DMA_CH1_DONE_REQ_I(src[9]),
    .CLOCKED_SERIAL0_REQ_I(src[10]), .SERIAL1_TX_REQ_I(src[11]),
    .CLOCKED_SERIAL1_REQ_I(cs1), .TWO_WIRE1_REQ_I(tw1),
    .SERIAL1_RX_REQ_I(src[12]), .SERIAL1_ERR_REQ_I(src[13]),
    .TIMER_U0_REQ_I({src[25:22], src[17:14]}), .TIMER_U1_REQ_I({src[21], src[29:27]}),
    .RTC_CYCLE_ALARM_REQ_I(src[18]), .RTC_INTERVAL_REQ_I(src[19]),
    .SERIAL2_TX_REQ_I(src[20]), .DIVIDE_DONE_REQ_I(src[30]), .BREAK_INSTRUCTION_I(break_instruction),
    .WATCHDOG_INTERVAL_ENABLE_I(wdt_en), .LOW_VOLTAGE_RESET_SELECT_I(lv_sel),
    .MASK_I(mask), .ACK_I(ack), .INT_REQ_O(int_req), .VECTOR_O(vec),
    .INT_SRC_O(isrc), .PENDING_O(pend));

  core_fetch_model i_core (.clk_i(clk), .resetn_i(rstn), .int_req_i(int_req),
    .vector_i(vec), .int_src_i(isrc), .stray_ack_i(stray), .delay_i(delay),
    .ack_o(ack), .last_vec_o(lvec), .last_src_o(lsrc), .taken_o(taken));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Count a comparison, report a mismatch
  task automatic chk(input bit bad, input string msg);
    compares++;
    if (bad) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // One-cycle pulse on the chosen sources
  task automatic pulse(input logic [30:0] v, input logic b);
    @(negedge clk);
    src = v;
    break_instruction = b;
    @(negedge clk);
    src = '0;
    break_instruction = 1'b0;
  endtask

  // Wait, bounded, for the next fetch and judge it
  task automatic serve(input int idx);
    int k;
    k = 0;
    while (taken == seen && k < 300) begin
      @(negedge clk);
      k++;
    end
    seen = taken;
    chk(k >= 300 || lsrc !== idx[4:0] || lvec !== exp_vec[idx], $sformatf("grant %0d", idx));
  endtask

  // Nothing may be offered for n cycles
  task automatic none(input int n);
    repeat (n) @(negedge clk);
    chk(taken != seen || int_req !== 1'b0, "unexpected grant");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_vectors();
    for (int i = 0; i < 14; i++) begin
      pulse(31'(1) << i, 1'b0);
      serve(i);
    end
    for (int i = 14; i < 31; i++) begin
      pulse(31'(1) << i, 1'b0);
      serve(i);
    end
  endtask

  // All sources at once, slow core: served strictly by number, none lost
  task automatic t_order();
    delay = 4;
    pulse('1, 1'b0);
    for (int i = 0; i < 31; i++) serve(i);
    delay = 0;
  endtask

  // Masked request waits pending while a lower one is served
  task automatic t_mask();
    mask = 31'(1) << 5;
    pulse((31'(1) << 5) | (31'(1) << 20), 1'b0);
    serve(20);
    none(8);
    chk(pend[5] !== 1'b1, "masked flag lost");
    mask = '0;
    serve(5);
  endtask

  // Break goes through with every mask set
  task automatic t_break();
    mask = '1;
    pulse(31'(1) << 3, 1'b1);
    serve(31);
    none(6);
    mask = '0;
    serve(3);
  endtask

  // Gated sources are dropped; idle ack is ignored
  task automatic t_gates();
    wdt_en = 1'b0;
    lv_sel = 1'b1;
    stray = 1'b1;
    pulse(31'h3, 1'b0);
    none(10);
    chk(pend !== '0, "gated source pended");
    stray = 1'b0;
    wdt_en = 1'b1;
    lv_sel = 1'b0;
  endtask

  // Clocked and two-wire events of serial 1 share its transmit request
  task automatic t_shared();
    @(negedge clk);
    cs1 = 1'b1;
    @(negedge clk);
    cs1 = 1'b0;
    serve(11);
    @(negedge clk);
    tw1 = 1'b1;
    @(negedge clk);
    tw1 = 1'b0;
    serve(11);
  endtask

  // ****************************************************************
  // Verdict and main sequence
  // ****************************************************************
  task automatic summarize();
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    exp_vec = '{`VEC_WDT, `VEC_LVI, `VEC_PIN_A, `VEC_PIN_B, `VEC_PIN_C, `VEC_S3_TX,
      `VEC_S3_RX, `VEC_S3_ERR, `VEC_DMA0, `VEC_DMA1, `VEC_CS0, `VEC_S1_TX, `VEC_S1_RX,
      `VEC_S1_ERR, `VEC_U0_CH0, `VEC_U0_CH1, `VEC_U0_CH2, `VEC_U0_CH3, `VEC_RTC_CYC,
      `VEC_RTC_INT, `VEC_S2_TX, `VEC_U1_CH3, `VEC_U0_CH4, `VEC_U0_CH5, `VEC_U0_CH6,
      `VEC_U0_CH7, `VEC_PIN_D, `VEC_U1_CH0, `VEC_U1_CH1, `VEC_U1_CH2, `VEC_DIV, `VEC_SWI};
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk(int_req !== 1'b0 || pend !== '0 || vec !== '0 || isrc !== '0, "outputs after reset");
    t_vectors();
    t_order();
    t_mask();
    t_break();
    t_gates();
    t_shared();
    summarize();
  end

  // Whole run needs under a thousand cycles; this bound of 20000 cycles catches a hang
  initial begin
    #(50 * 20000);
    err_count++;
    summarize();
  end
endmodule // tb
